//--- uhf_host_timer.sv
// Host status flags, frame interval down counter and next frame number, two engines.
// Assumes line inputs come from pins (synchronised here), SIE strobes from mclk_i logic.
`timescale 1ns/1ps
`include "uhf_map.svh"

module uhf_host_timer #(
    parameter int unsigned RELOAD_W = 14,
    parameter int unsigned FRAME_W = 11
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Processor register port
    input wire uhf_pkg::uhf_bus_req_t cpu_req_i,
    output logic [15:0] cpu_rdata_o,
    output logic cpu_rvalid_o,
    // Port line conditions, one set per engine; the OTG levels are single and serve engine 1 only
    input wire uhf_pkg::uhf_lines_t [1:0] lines_i,
    input wire logic otg_vbus_valid_i,
    input wire logic otg_id_i,
    // SIE strobes, one bit per engine
    input wire logic [1:0] xfer_done_i,
    input wire logic [1:0] host_active_i,
    input wire logic [1:0] sof_sent_i,
    // Frame and interrupt outputs, one bit per engine
    output logic [1:0] sof_req_o,
    output logic [1:0] irq_o
);
    import uhf_pkg::*;

    // ------------------------------------------------------------------------
    // Rate constants
    // ------------------------------------------------------------------------
    localparam logic [7:0] TICK_NUM = 8'(`UHF_TICK_HZ / `UHF_RATE_UNIT);
    localparam logic [7:0] TICK_DEN = 8'(`UHF_CLK_HZ / `UHF_RATE_UNIT);
    localparam int unsigned NSYNC = 10;
    // Synchronisers start at the idle pin levels: empty ports sit in SE0, so no
    // false connect change follows reset
    localparam logic [NSYNC-1:0] SYNC_RST = 10'h330;

    // ------------------------------------------------------------------------
    // 12 MHz tick from the 100 MHz clock
    // ------------------------------------------------------------------------
    // Fractional accumulator: ticks are not evenly spaced, but average exactly 12 MHz
    logic [7:0] acc_q;
    logic [7:0] acc_sum;
    logic tick;

    assign acc_sum = acc_q + TICK_NUM;
    assign tick = (acc_sum >= TICK_DEN);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_q <= 8'h00;
        end else if (tick) begin
            acc_q <= acc_sum - TICK_DEN;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers and edge memory
    // ------------------------------------------------------------------------
    // Order: e2 se0_b, se0_a, wake_b, wake_a, e1 same, id, vbus
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    logic [NSYNC-1:0] pin_rise;
    logic [NSYNC-1:0] pin_fall;

    assign pin_raw = {lines_i[1], lines_i[0], otg_id_i, otg_vbus_valid_i};
    assign pin_rise = sync2_q & ~prev_q;
    assign pin_fall = ~sync2_q & prev_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            prev_q <= SYNC_RST;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ------------------------------------------------------------------------
    // Per-engine read results, joined below
    // ------------------------------------------------------------------------
    logic [1:0][15:0] rd_word;
    logic [1:0] rd_hit;

    // ------------------------------------------------------------------------
    // Host engines
    // ------------------------------------------------------------------------
    for (genvar e = 0; e < 2; e++) begin : g_eng
        localparam logic [15:0] OFS_EN = (e == 0) ? `UHF_H1_IRQ_EN_OFS : `UHF_H2_IRQ_EN_OFS;
        localparam logic [15:0] OFS_ST = (e == 0) ? `UHF_H1_STATUS_OFS : `UHF_H2_STATUS_OFS;
        localparam logic [15:0] OFS_RL = (e == 0) ? `UHF_H1_RELOAD_OFS : `UHF_H2_RELOAD_OFS;
        localparam logic [15:0] OFS_CN = (e == 0) ? `UHF_H1_COUNTER_OFS : `UHF_H2_COUNTER_OFS;
        localparam logic [15:0] OFS_FR = (e == 0) ? `UHF_H1_FRAME_OFS : `UHF_H2_FRAME_OFS;
        localparam logic [15:0] FMASK = (e == 0) ? `UHF_FLAG_MASK_E1 : `UHF_FLAG_MASK_E2;
        localparam int unsigned SB = 2 + 4 * e;

        logic [15:0] flag_q;
        logic [15:0] irq_en_q;
        logic [RELOAD_W-1:0] reload_q;
        logic [RELOAD_W-1:0] count_q;
        logic [FRAME_W-1:0] frame_q;
        logic sof_req_q;
        logic [15:0] ev;
        logic [15:0] status_word;
        logic expire;
        logic wr_en_reg;
        logic wr_st_reg;
        logic wr_rl_reg;
        logic se0_b;
        logic se0_a;

        assign wr_en_reg = cpu_req_i.wr_en && (cpu_req_i.addr == OFS_EN);
        assign wr_st_reg = cpu_req_i.wr_en && (cpu_req_i.addr == OFS_ST);
        assign wr_rl_reg = cpu_req_i.wr_en && (cpu_req_i.addr == OFS_RL);
        assign expire = tick && (count_q == '0);
        assign se0_b = sync2_q[SB+3];
        assign se0_a = sync2_q[SB+2];

        // Event strobes, all on mclk_i edges
        always_comb begin
            ev = 16'h0000;
            if (e == 0) begin
                ev[`UHF_BIT_VBUS] = pin_rise[0] | pin_fall[0];
                ev[`UHF_BIT_ID] = pin_rise[1] | pin_fall[1];
            end
            ev[`UHF_BIT_SOF] = expire;
            ev[`UHF_BIT_WAKE_B] = pin_rise[SB+1];
            ev[`UHF_BIT_WAKE_A] = pin_rise[SB];
            ev[`UHF_BIT_CONN_B] = pin_rise[SB+3] | pin_fall[SB+3];
            ev[`UHF_BIT_CONN_A] = pin_rise[SB+2] | pin_fall[SB+2];
            ev[`UHF_BIT_DONE] = xfer_done_i[e];
        end

        // Sticky flags; a new event beats a clear in the same cycle
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                flag_q <= 16'h0000;
            end else if (wr_st_reg) begin
                flag_q <= ((flag_q & ~cpu_req_i.wdata) | ev) & FMASK;
            end else begin
                flag_q <= (flag_q | ev) & FMASK;
            end
        end

        // Interrupt enables; reserved positions never store
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                irq_en_q <= 16'h0000;
            end else if (wr_en_reg) begin
                irq_en_q <= cpu_req_i.wdata & FMASK;
            end
        end

        assign irq_o[e] = |(flag_q & irq_en_q);

        // Reload value; upper bits dropped, software keeps them zero
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                reload_q <= `UHF_RELOAD_RST;
            end else if (wr_rl_reg) begin
                reload_q <= cpu_req_i.wdata[RELOAD_W-1:0];
            end
        end

        // Down counter; a new reload value only takes effect at the next expiry
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                count_q <= `UHF_RELOAD_RST;
            end else if (expire) begin
                count_q <= reload_q;
            end else if (tick) begin
                count_q <= count_q - 1'b1;
            end
        end

        // Start of frame request, one cycle per reload while the host runs
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                sof_req_q <= 1'b0;
            end else begin
                sof_req_q <= expire && host_active_i[e];
            end
        end

        assign sof_req_o[e] = sof_req_q;

        // Next frame number; a reload write wins over a coincident advance
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                frame_q <= `UHF_FRAME_RST;
            end else if (wr_rl_reg) begin
                frame_q <= `UHF_FRAME_RST;
            end else if (sof_sent_i[e]) begin
                frame_q <= frame_q + 1'b1;
            end
        end

        // Status word with live SE0 levels; writes to those bits are ignored
        always_comb begin
            status_word = flag_q;
            status_word[`UHF_BIT_SE0_B] = se0_b;
            status_word[`UHF_BIT_SE0_A] = se0_a;
        end

        // Read decode for this engine
        always_comb begin
            rd_hit[e] = 1'b1;
            case (cpu_req_i.addr)
                OFS_EN: rd_word[e] = irq_en_q;
                OFS_ST: rd_word[e] = status_word;
                OFS_RL: rd_word[e] = 16'(reload_q);
                OFS_CN: rd_word[e] = 16'(count_q);
                OFS_FR: rd_word[e] = 16'(frame_q);
                default: begin
                    rd_hit[e] = 1'b0;
                    rd_word[e] = 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------------------
    // Unmapped reads return zero; the valid strobe still answers every read
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cpu_rdata_o <= 16'h0000;
            cpu_rvalid_o <= 1'b0;
        end else begin
            cpu_rvalid_o <= cpu_req_i.rd_en;
            if (cpu_req_i.rd_en) begin
                cpu_rdata_o <= rd_hit[0] ? rd_word[0] : rd_word[1];
            end
        end
    end

endmodule

//--- uhf_host_timer_chk.sv
// Concurrent checks on the host frame timer top-level ports.
// Assumes the map header is reachable by bare name; bound at the foot.
`timescale 1ns/1ps
`include "uhf_map.svh"
module uhf_host_timer_chk #(
    parameter int unsigned RELOAD_W = 14,
    parameter int unsigned FRAME_W = 11
) (
    // Clock, reset and processor port
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire uhf_pkg::uhf_bus_req_t cpu_req_i,
    input wire logic [15:0] cpu_rdata_o,
    input wire logic cpu_rvalid_o,
    // Line, strobe and frame side
    input wire uhf_pkg::uhf_lines_t [1:0] lines_i,
    input wire logic otg_vbus_valid_i,
    input wire logic otg_id_i,
    input wire logic [1:0] xfer_done_i,
    input wire logic [1:0] host_active_i,
    input wire logic [1:0] sof_sent_i,
    input wire logic [1:0] sof_req_o,
    input wire logic [1:0] irq_o
);
    import uhf_pkg::*;
    logic rd;
    logic [15:0] ad;
    assign rd = cpu_req_i.rd_en;
    assign ad = cpu_req_i.addr;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_read_answer: assert property (rd |=> cpu_rvalid_o)
        else $error("read not answered next cycle");
    a_no_stray_rvalid: assert property (!rd |=> !cpu_rvalid_o)
        else $error("read valid without a read");
    a_rdata_holds: assert property (!cpu_rvalid_o |-> $stable(cpu_rdata_o))
        else $error("read data moved without a read");
    a_reload_upper_zero: assert property (rd && (ad == `UHF_H1_RELOAD_OFS ||
        ad == `UHF_H2_RELOAD_OFS) |=> cpu_rdata_o[15:RELOAD_W] == '0)
        else $error("reload upper bits not zero");
    a_count_upper_zero: assert property (rd && (ad == `UHF_H1_COUNTER_OFS ||
        ad == `UHF_H2_COUNTER_OFS) |=> cpu_rdata_o[15:RELOAD_W] == '0)
        else $error("counter upper bits not zero");
    a_frame_upper_zero: assert property (rd && (ad == `UHF_H1_FRAME_OFS ||
        ad == `UHF_H2_FRAME_OFS) |=> cpu_rdata_o[15:FRAME_W] == '0)
        else $error("frame upper bits not zero");
    a_eng2_otg_zero: assert property (rd && ad == `UHF_H2_STATUS_OFS
        |=> cpu_rdata_o[15:14] == 2'b00)
        else $error("engine 2 otg flags not zero");
    a_unmapped_zero: assert property (rd && ad[15:8] != 8'hc0
        |=> cpu_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_sof_pulse_gap: assert property (sof_req_o[0] |=> !sof_req_o[0] [*7])
        else $error("frame requests closer than one tick");
    a_sof_needs_active: assert property ((sof_req_o & ~$past(host_active_i)) == 2'b00)
        else $error("frame request while host idle");
endmodule
bind uhf_host_timer uhf_host_timer_chk #(.RELOAD_W(RELOAD_W), .FRAME_W(FRAME_W))
    uhf_host_timer_chk_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cpu_req_i(cpu_req_i),
    .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o), .lines_i(lines_i),
    .otg_vbus_valid_i(otg_vbus_valid_i), .otg_id_i(otg_id_i), .xfer_done_i(xfer_done_i),
    .host_active_i(host_active_i), .sof_sent_i(sof_sent_i), .sof_req_o(sof_req_o),
    .irq_o(irq_o));

//--- uhf_host_timer_tb.sv
// Self-checking bench for the host frame timer.
// Assumes the checker is bound and the line model drives the port lines.
`timescale 1ns/1ps
`include "uhf_map.svh"
module uhf_host_timer_tb;
    import uhf_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    uhf_bus_req_t cpu_req_i = '0;
    logic [15:0] cpu_rdata_o;
    logic cpu_rvalid_o;
    uhf_lines_t [1:0] lines_i;
    logic otg_vbus_valid_i = 1'b0;
    logic otg_id_i = 1'b0;
    logic [1:0] xfer_done_i = 2'b00;
    logic [1:0] host_active_i = 2'b01;
    logic [1:0] sof_sent_i = 2'b00;
    logic [1:0] sof_req_o;
    logic [1:0] irq_o;
    logic [1:0] att_a = 2'b00;
    logic [1:0] att_b = 2'b00;
    logic [1:0] wk_a = 2'b00;
    logic [1:0] wk_b = 2'b00;
    logic [15:0] v;
    logic [15:0] c0;
    logic [15:0] ev_bit [8] = '{16'h0010, 16'h0020, 16'h0040, 16'h0080,
                                16'h8000, 16'h4000, 16'h8000, 16'h4000};
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n = 0;
    uhf_host_timer uhf_host_timer_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
        .lines_i(lines_i), .otg_vbus_valid_i(otg_vbus_valid_i), .otg_id_i(otg_id_i),
        .xfer_done_i(xfer_done_i), .host_active_i(host_active_i),
        .sof_sent_i(sof_sent_i), .sof_req_o(sof_req_o), .irq_o(irq_o));
    uhf_line_model uhf_line_model_inst (.att_a_i(att_a), .att_b_i(att_b),
        .wk_a_i(wk_a), .wk_b_i(wk_b), .lines_o(lines_i));
    // ----
    // Tasks
    // ----
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        cpu_req_i <= '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wdata: d};
        @(posedge mclk_i);
        cpu_req_i.wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        cpu_req_i <= '{addr: a, wr_en: 1'b0, rd_en: 1'b1, wdata: 16'h0000};
        @(posedge mclk_i);
        cpu_req_i.rd_en <= 1'b0;
        #1;
        d = cpu_rdata_o;
    endtask
    task automatic rdm(input string nm, input logic [15:0] a, m, e);
        rd(a, v);
        check(nm, v & m, e);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Long enough for one full power-up frame plus the fast frames
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 110000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rdm("reload1", `UHF_H1_RELOAD_OFS, 16'hffff, 16'h2ee0);
        rdm("reload2", `UHF_H2_RELOAD_OFS, 16'hffff, 16'h2ee0);
        rdm("frame1", `UHF_H1_FRAME_OFS, 16'hffff, 16'h0000);
        rdm("unmapped", 16'h1234, 16'hffff, 16'h0000);
        wr(`UHF_H1_RELOAD_OFS, 16'h0010);
        rdm("reload1 back", `UHF_H1_RELOAD_OFS, 16'hffff, 16'h0010);
        rdm("reload2 kept", `UHF_H2_RELOAD_OFS, 16'hffff, 16'h2ee0);
        // A read 100 cycles later spans exactly 12 ticks
        rd(`UHF_H1_COUNTER_OFS, c0);
        repeat (98) @(posedge mclk_i);
        rdm("count rate", `UHF_H1_COUNTER_OFS, 16'h3fff, c0 - 16'd12);
        for (int i = 0; i < 2050; i++) begin
            @(posedge mclk_i);
            sof_sent_i[0] <= 1'b1;
            @(posedge mclk_i);
            sof_sent_i[0] <= 1'b0;
        end
        rdm("frame wrap", `UHF_H1_FRAME_OFS, 16'hffff, 16'h0002);
        rdm("frame2", `UHF_H2_FRAME_OFS, 16'hffff, 16'h0000);
        wr(`UHF_H1_RELOAD_OFS, 16'h0010);
        rdm("frame clear", `UHF_H1_FRAME_OFS, 16'hffff, 16'h0000);
        wr(`UHF_H1_IRQ_EN_OFS, 16'hffff);
        wr(`UHF_H2_IRQ_EN_OFS, 16'hffff);
        wr(`UHF_H2_STATUS_OFS, 16'hffff);
        rdm("done clear", `UHF_H2_STATUS_OFS, 16'h0001, 16'h0000);
        @(posedge mclk_i);
        xfer_done_i <= 2'b10;
        @(posedge mclk_i);
        xfer_done_i <= 2'b00;
        rdm("done", `UHF_H2_STATUS_OFS, 16'h0001, 16'h0001);
        check("irq on", {14'h0, irq_o}, 16'h0002);
        wr(`UHF_H2_STATUS_OFS, 16'h0000);
        rdm("write zero", `UHF_H2_STATUS_OFS, 16'h0001, 16'h0001);
        wr(`UHF_H2_IRQ_EN_OFS, 16'h0000);
        #1;
        check("irq masked", {15'h0, irq_o[1]}, 16'h0000);
        wr(`UHF_H2_STATUS_OFS, 16'h0001);
        rdm("write one", `UHF_H2_STATUS_OFS, 16'h0001, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            wr(`UHF_H1_STATUS_OFS, 16'hffff);
            @(posedge mclk_i);
            case (k)
                0: att_a[0] <= 1'b1;
                1: att_b[0] <= 1'b1;
                2: wk_a[0] <= 1'b1;
                3: wk_b[0] <= 1'b1;
                4, 6: otg_vbus_valid_i <= !otg_vbus_valid_i;
                default: otg_id_i <= !otg_id_i;
            endcase
            repeat (5) @(posedge mclk_i);
            wk_a <= 2'b00;
            wk_b <= 2'b00;
            rdm("event", `UHF_H1_STATUS_OFS, 16'hc2f0, ev_bit[k]);
        end
        rdm("se0 live", `UHF_H1_STATUS_OFS, 16'h000c, 16'h0000);
        rdm("otg reserved", `UHF_H2_STATUS_OFS, 16'hc000, 16'h0000);
        @(posedge mclk_i);
        att_a[0] <= 1'b0;
        repeat (5) @(posedge mclk_i);
        rdm("removal", `UHF_H1_STATUS_OFS, 16'h003c, 16'h0014);
        wr(`UHF_H1_STATUS_OFS, 16'hffff);
        // The power-up count still runs; its expiry sets the frame flag
        #1;
        while (irq_o[0] !== 1'b1 && cyc < 101500) begin
            @(posedge mclk_i);
            #1;
        end
        rdm("expiry", `UHF_H1_STATUS_OFS, 16'h0200, 16'h0200);
        // 1700 cycles hold 204 ticks, twelve periods of reload plus one
        repeat (1700) begin
            @(posedge mclk_i);
            #1;
            n += sof_req_o[0];
        end
        check("sof pulses", 16'(n), 16'd12);
        close_out();
    end
endmodule

//--- uhf_line_model.sv
// Devices on ports A and B of both engines, seen as line conditions.
// Assumes the bench commands attach and wakeup per engine.
`timescale 1ns/1ps
module uhf_line_model (
    // Commands, one bit per engine
    input wire logic [1:0] att_a_i,
    input wire logic [1:0] att_b_i,
    input wire logic [1:0] wk_a_i,
    input wire logic [1:0] wk_b_i,
    // Line conditions seen by the host
    output uhf_pkg::uhf_lines_t [1:0] lines_o
);
    import uhf_pkg::*;
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            // Pull-downs give SE0 while nothing is attached
            lines_o[e].se0_a = !att_a_i[e];
            lines_o[e].se0_b = !att_b_i[e];
            // Only an attached device can signal wakeup
            lines_o[e].wake_a = att_a_i[e] & wk_a_i[e];
            lines_o[e].wake_b = att_b_i[e] & wk_b_i[e];
        end
    end
endmodule

//--- uhf_map.svh
// Register offsets, field positions, reset values and timing figures of the host frame timer.
// Assumes inclusion by bare name from the design file, the checker and the bench.
`ifndef UHF_MAP_SVH
`define UHF_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets, engine 1 and engine 2
// ----------------------------------------------------------------------------
`define UHF_H1_IRQ_EN_OFS 16'hc08c
`define UHF_H1_STATUS_OFS 16'hc090
`define UHF_H1_RELOAD_OFS 16'hc092
`define UHF_H1_COUNTER_OFS 16'hc094
`define UHF_H1_FRAME_OFS 16'hc096
`define UHF_H2_IRQ_EN_OFS 16'hc0ac
`define UHF_H2_STATUS_OFS 16'hc0b0
`define UHF_H2_RELOAD_OFS 16'hc0b2
`define UHF_H2_COUNTER_OFS 16'hc0b4
`define UHF_H2_FRAME_OFS 16'hc0b6

// ----------------------------------------------------------------------------
// Status and enable bit positions
// ----------------------------------------------------------------------------
`define UHF_BIT_VBUS 15
`define UHF_BIT_ID 14
`define UHF_BIT_SOF 9
`define UHF_BIT_WAKE_B 7
`define UHF_BIT_WAKE_A 6
`define UHF_BIT_CONN_B 5
`define UHF_BIT_CONN_A 4
`define UHF_BIT_SE0_B 3
`define UHF_BIT_SE0_A 2
`define UHF_BIT_DONE 0

// Sticky flags and enables; engine 2 lacks the OTG bits
`define UHF_FLAG_MASK_E1 16'hc2f1
`define UHF_FLAG_MASK_E2 16'h02f1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define UHF_RELOAD_RST 14'h2ee0
`define UHF_FRAME_RST 11'h000
`define UHF_CLK_HZ 100000000
`define UHF_TICK_HZ 12000000
`define UHF_RATE_UNIT 1000000

`endif

//--- uhf_pkg.sv
// Types shared by the host frame timer and whoever drives its ports.
// Assumes the map header sits in the same folder.
package uhf_pkg;

    // ------------------------------------------------------------------------
    // Processor register access
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic wr_en;
        logic rd_en;
        logic [15:0] wdata;
    } uhf_bus_req_t;

    // ------------------------------------------------------------------------
    // Line conditions of one engine's two ports
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic se0_b;
        logic se0_a;
        logic wake_b;
        logic wake_a;
    } uhf_lines_t;

endpackage
